/* almon_monitor.sv */
/*
  limit checking with hysteresis, alert flags, alert pins, and min/max tracking per channel, as an apb slave.
  assumes conversion results arrive synchronous to pclk as a one-cycle conv_valid strobe; channel 8 is temperature.
*/
// Our own choices: the APB interface to the registers and the placing of the registers.
// Overview of operation
// R1: limits and hysteresis are 10-bit values left-aligned in 16 bits, low six zero.
// R2: reset loads low limits and hysteresis with zero, high limits with 0xffc0.
// R3: a result strictly above the high limit raises that channel's high alert.
// R4: a result strictly below the low limit raises that channel's low alert.
// R5: with hysteresis on, release needs N codes below high or above low limit.
// R6: two alert pins follow a selected channel's violation, polarity set by configuration.
// R7: unread flags follow the next conversion, and the pin drops when back in range.
// R8: result words carry summary bits for any channel currently in violation.
// R9: two flag registers, voltage and temperature, high and low bit per channel.
// R10: voltage flag bit 14 is channel 7 low, bit 3 is channel 1 high.
// R11: channel n low flag is bit 2n, high is 2n+1; temperature uses bits 0,1.
// R12: later violations on other channels set their own flags beside earlier ones.
// R13: flags update on every conversion and clear when back within limits.
// R14: read-and-reset access to a flag register returns flags and clears them.
// R15: writing 0xffff or 0x0003 to the flag registers clears all their flags.
// R16: per channel min and max results are tracked, read-only, left-aligned.
// R17: any write to a min or max register restores its power-up value.
// R18: read-and-reset access to min or max returns the value then restores it.
// R19: reset sets every minimum to 0xffc0 and every maximum to zero.
// R20: without hysteresis or with zero count, alerts clear once back within the limit.
// R21: the host flags read-and-reset with both pointer bits; here the alias address bit.
`timescale 1ns/1ps
`default_nettype none
module almon_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [almon_pkg::AW-1:0] paddr,
  input wire logic [almon_pkg::DW-1:0] pwdata,
  output logic [almon_pkg::DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_valid,
  input wire almon_pkg::almon_conv_t conv,
  output logic first_alert_output_pin,
  output logic second_alert_output_pin
);
  import almon_pkg::*;

  // true when a group/index pair names a mapped register
  function automatic logic addr_hit(input logic [2:0] g, input logic [3:0] i);
    if (g == GRP_MISC) begin
      addr_hit = (i <= IDX_RESULT);
    end else begin
      addr_hit = (g <= GRP_MAX) && (i < 4'(NCH));
    end
  endfunction : addr_hit

  // pin level from alert activity, enable and polarity
  function automatic logic pin_level(input logic act, input logic en, input logic pol);
    pin_level = en ? (pol ? act : ~act) : ~pol;
  endfunction : pin_level

  almon_cfg_t cfg_r;
  almon_apb_st_t st_r;
  almon_apb_st_t st_nxt;
  logic [DW-1:0] prdata_r;
  logic [DW-1:0] rd_word;
  logic [3:0] res_chan_r;
  logic [CODE_W-1:0] res_code_r;
  logic pin0_r;
  logic pin1_r;
  logic [CODE_W-1:0] hi_v [NCH];
  logic [CODE_W-1:0] lo_v [NCH];
  logic [CODE_W-1:0] hy_v [NCH];
  logic [CODE_W-1:0] mn_v [NCH];
  logic [CODE_W-1:0] mx_v [NCH];
  logic [NCH-1:0] ah_v;
  logic [NCH-1:0] al_v;
  logic [NCH-1:0] fh_v;
  logic [NCH-1:0] fl_v;
  logic [15:0] aflag_w;
  logic [15:0] tflag_w;

  // address decode
  wire [2:0] grp = paddr[GRP_LSB +: 3];
  wire [3:0] idx = paddr[IDX_LSB +: 4];
  wire rr_alias = paddr[ADDR_RR_BIT];
  wire hit = addr_hit(grp, idx);
  wire done = psel & penable & pready;
  wire wr_go = done & pwrite & hit & pclk_en;
  wire rr_go = done & ~pwrite & hit & rr_alias & pclk_en; // R21
  wire capture = pclk_en & psel & ~pwrite & (st_r == ST_IDLE);
  wire is_aflag = (grp == GRP_MISC) && (idx == IDX_AFLAG);
  wire is_tflag = (grp == GRP_MISC) && (idx == IDX_TFLAG);

  // apb handshake: ready once read data has been captured, error on unmapped address
  assign st_nxt = done ? ST_IDLE : ((psel && st_r == ST_IDLE && (pwrite || pclk_en)) ? ST_HELD : st_r);
  assign pready = psel & penable & pclk_en & (st_r == ST_HELD);
  assign pslverr = pready & ~hit;
  assign prdata = prdata_r;

  // summary alert bits over all channels
  wire a_any = |(ah_v[CH_TEMP-1:0] | al_v[CH_TEMP-1:0]); // R8
  wire t_any = ah_v[CH_TEMP] | al_v[CH_TEMP]; // R8

  // flag words: voltage channel n low at 2n, high at 2n+1; temperature low at bit 0, high at bit 1
  genvar f;
  generate
    for (f = 0; f < CH_TEMP; f++) begin : g_fw
      assign aflag_w[2*f] = fl_v[f]; // R10 R11
      assign aflag_w[2*f+1] = fh_v[f]; // R10 R11
    end
  endgenerate
  assign tflag_w = {14'h0000, fh_v[CH_TEMP], fl_v[CH_TEMP]}; // R9 R11

  // bits to clear: write-one-to-clear data, or the captured value on read-and-reset
  wire [15:0] clr_a = (wr_go & is_aflag) ? pwdata[15:0] : ((rr_go & is_aflag) ? prdata_r[15:0] : 16'h0000); // R14 R15
  wire [15:0] clr_t = (wr_go & is_tflag) ? pwdata[15:0] : ((rr_go & is_tflag) ? prdata_r[15:0] : 16'h0000); // R14 R15

  // read mux, limit and min/max values left-aligned with zero padding
  wire [3:0] ci = (idx < 4'(NCH)) ? idx : 4'h0;
  always_comb begin
    rd_word = '0;
    case (grp)
      GRP_MISC: begin
        case (idx)
          IDX_CFG: rd_word = {20'h00000, cfg_r};
          IDX_AFLAG: rd_word = {16'h0000, aflag_w};
          IDX_TFLAG: rd_word = {16'h0000, tflag_w};
          IDX_RESULT: rd_word = {16'h0000, res_code_r, res_chan_r, t_any, a_any}; // R8
          default: rd_word = '0;
        endcase
      end
      GRP_HI: rd_word = {16'h0000, hi_v[ci], 6'h00}; // R1
      GRP_LO: rd_word = {16'h0000, lo_v[ci], 6'h00}; // R1
      GRP_HYS: rd_word = {16'h0000, hy_v[ci], 6'h00}; // R1
      GRP_MIN: rd_word = {16'h0000, mn_v[ci], 6'h00}; // R16
      GRP_MAX: rd_word = {16'h0000, mx_v[ci], 6'h00}; // R16
      default: rd_word = '0;
    endcase
    if (!hit) begin
      rd_word = '0;
    end
  end

  // bus state, captured read data, configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      prdata_r <= '0;
      cfg_r <= CFG_RST;
    end else if (pclk_en) begin
      st_r <= st_nxt;
      if (capture) begin
        prdata_r <= rd_word;
      end
      if (wr_go && grp == GRP_MISC && idx == IDX_CFG) begin
        cfg_r <= pwdata[11:0];
      end
    end
  end

  // last result word and registered alert pins
  wire sel0_act = (cfg_r.sel0 == SEL_ANY) ? (a_any | t_any) : (cfg_r.sel0 < 4'(NCH) && (ah_v[cfg_r.sel0 % NCH] | al_v[cfg_r.sel0 % NCH]));
  wire sel1_act = (cfg_r.sel1 == SEL_ANY) ? (a_any | t_any) : (cfg_r.sel1 < 4'(NCH) && (ah_v[cfg_r.sel1 % NCH] | al_v[cfg_r.sel1 % NCH]));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_chan_r <= 4'h0;
      res_code_r <= '0;
      pin0_r <= 1'b1;
      pin1_r <= 1'b1;
    end else if (pclk_en) begin
      if (conv_valid) begin
        res_chan_r <= conv.chan;
        res_code_r <= conv.code;
      end
      pin0_r <= pin_level(sel0_act, cfg_r.pin0_en, cfg_r.pol_high); // R6 R7
      pin1_r <= pin_level(sel1_act, cfg_r.pin1_en, cfg_r.pol_high); // R6 R7
    end
  end
  assign first_alert_output_pin = pin0_r;
  assign second_alert_output_pin = pin1_r;

  // per channel limits, alert state, flags and min/max
  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      logic [CODE_W-1:0] hi_r;
      logic [CODE_W-1:0] lo_r;
      logic [CODE_W-1:0] hy_r;
      logic [CODE_W-1:0] mn_r;
      logic [CODE_W-1:0] mx_r;
      logic ah_r;
      logic al_r;
      logic fh_r;
      logic fl_r;
      logic clr_lo;
      logic clr_hi;
      if (i == CH_TEMP) begin : g_t
        assign clr_lo = clr_t[0];
        assign clr_hi = clr_t[1];
      end else begin : g_a
        assign clr_lo = clr_a[2*i];
        assign clr_hi = clr_a[2*i+1];
      end
      wire cv = conv_valid & (conv.chan == 4'(i));
      wire [CODE_W:0] code_x = {1'b0, conv.code};
      wire hys = cfg_r.hyst_en;
      // alert with hysteresis hold
      wire hi_nxt = (code_x > {1'b0, hi_r}) | (ah_r & hys & ((code_x + {1'b0, hy_r}) > {1'b0, hi_r})); // R3 R5 R20
      wire lo_nxt = (code_x < {1'b0, lo_r}) | (al_r & hys & (code_x < ({1'b0, lo_r} + {1'b0, hy_r}))); // R4 R5 R20
      wire wsel = wr_go & (idx == 4'(i));
      wire mn_clr = (wsel & grp == GRP_MIN) | (rr_go & grp == GRP_MIN & idx == 4'(i) & mn_r == prdata_r[15:6]); // R17 R18
      wire mx_clr = (wsel & grp == GRP_MAX) | (rr_go & grp == GRP_MAX & idx == 4'(i) & mx_r == prdata_r[15:6]); // R17 R18
      wire [CODE_W-1:0] mn_base = mn_clr ? MIN_RST[15:6] : mn_r;
      wire [CODE_W-1:0] mx_base = mx_clr ? MAX_RST[15:6] : mx_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hi_r <= LIM_HI_RST[15:6]; // R2
          lo_r <= LIM_LO_RST[15:6]; // R2
          hy_r <= HYST_RST[15:6]; // R2
          mn_r <= MIN_RST[15:6]; // R19
          mx_r <= MAX_RST[15:6]; // R19
          ah_r <= 1'b0;
          al_r <= 1'b0;
          fh_r <= 1'b0;
          fl_r <= 1'b0;
        end else if (pclk_en) begin
          if (wsel && grp == GRP_HI) begin
            hi_r <= pwdata[15:6]; // R1
          end
          if (wsel && grp == GRP_LO) begin
            lo_r <= pwdata[15:6]; // R1
          end
          if (wsel && grp == GRP_HYS) begin
            hy_r <= pwdata[15:6]; // R1
          end
          if (cv) begin
            ah_r <= hi_nxt;
            al_r <= lo_nxt;
          end
          // conversion beats a clear in the same cycle
          fh_r <= cv ? hi_nxt : (fh_r & ~clr_hi); // R7 R12 R13 R14 R15
          fl_r <= cv ? lo_nxt : (fl_r & ~clr_lo); // R7 R12 R13 R14 R15
          mn_r <= (cv && conv.code < mn_base) ? conv.code : mn_base; // R16
          mx_r <= (cv && conv.code > mx_base) ? conv.code : mx_base; // R16
        end
      end
      assign hi_v[i] = hi_r;
      assign lo_v[i] = lo_r;
      assign hy_v[i] = hy_r;
      assign mn_v[i] = mn_r;
      assign mx_v[i] = mx_r;
      assign ah_v[i] = ah_r;
      assign al_v[i] = al_r;
      assign fh_v[i] = fh_r;
      assign fl_v[i] = fl_r;
    end
  endgenerate

  // checks on channels 1 and 7 (two of the three channels the bench exercises, with 8) and the bus, all in the pclk domain
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire c0 = pclk_en & conv_valid & (conv.chan == 4'h1);
  wire c7 = pclk_en & conv_valid & (conv.chan == 4'h7);

  a_high_sets_alert: assert property (c0 && conv.code > hi_v[1] |=> ah_v[1] && fh_v[1]) // R3
    else $error("high violation did not raise alert");
  a_low_sets_alert: assert property (c7 && conv.code < lo_v[7] |=> al_v[7] && fl_v[7]) // R4
    else $error("low violation did not raise alert");
  a_plain_release: assert property (c0 && !cfg_r.hyst_en && conv.code <= hi_v[1] && conv.code >= lo_v[1]
    |=> !ah_v[1] && !al_v[1] && !fh_v[1]) // R20
    else $error("alert held without hysteresis");
  a_hyst_hold: assert property (c0 && cfg_r.hyst_en && ah_v[1] && conv.code <= hi_v[1]
    && ({1'b0, conv.code} + {1'b0, hy_v[1]}) > {1'b0, hi_v[1]} |=> ah_v[1]) // R5
    else $error("alert released inside hysteresis band");
  a_pin_follows: assert property (pclk_en && cfg_r.pin0_en && cfg_r.pol_high && cfg_r.sel0 == 4'h1
    && (ah_v[1] || al_v[1]) ##1 pclk_en && $stable(cfg_r) |-> first_alert_output_pin) // R6
    else $error("alert pin not active");
  a_summary_bits: assert property (capture && grp == GRP_MISC && idx == IDX_RESULT
    |=> prdata[RES_AANY_BIT] == $past(a_any) && prdata[RES_TANY_BIT] == $past(t_any)) // R8
    else $error("summary bits wrong in result word");
  a_flag_blanket: assert property (wr_go && is_aflag && pwdata[15:0] == 16'hffff && !conv_valid
    |=> aflag_w == 16'h0000) // R15
    else $error("blanket write left flags set");
  a_min_restore: assert property (wr_go && grp == GRP_MIN && idx == 4'h1 && !c0
    |=> mn_v[1] == MIN_RST[15:6]) // R17
    else $error("min write did not restore power-up value");
  a_limit_pad: assert property (capture && (grp == GRP_HI || grp == GRP_LO || grp == GRP_HYS)
    |=> prdata[5:0] == 6'h00 ##1 1'b1) // R1
    else $error("limit padding bits not zero");

  c_rr_flags: cover property (rr_go && is_aflag && prdata_r[15:0] != 16'h0000);
  c_hyst_hold: cover property (c0 && cfg_r.hyst_en && ah_v[1] && conv.code <= hi_v[1] ##1 ah_v[1]);
  c_two_channels: cover property (fh_v[1] && fl_v[7]);
  c_unmapped: cover property (pslverr);
endmodule : almon_monitor
`default_nettype wire

/* almon_pkg.sv */
/*
  constants, field layouts and carrier types for the alert limit and min/max monitor.
  assumes a 100 MHz apb clock domain and one conversion result delivered per strobe.
*/
`default_nettype none
package almon_pkg;
  // channel set and code widths
  localparam int NCH = 9;
  localparam int CH_TEMP = 8;
  localparam int CODE_W = 10;
  localparam int PAD_W = 6;
  localparam int AW = 12;
  localparam int DW = 32;
  // power-up values of the left-aligned 16-bit registers
  localparam logic [15:0] LIM_HI_RST = 16'hffc0;
  localparam logic [15:0] LIM_LO_RST = 16'h0000;
  localparam logic [15:0] HYST_RST = 16'h0000;
  localparam logic [15:0] MIN_RST = 16'hffc0;
  localparam logic [15:0] MAX_RST = 16'h0000;
  // byte address layout: read-and-reset alias bit, group, register index
  localparam int ADDR_RR_BIT = 10;
  localparam int GRP_LSB = 6;
  localparam int IDX_LSB = 2;
  localparam logic [2:0] GRP_MISC = 3'h0;
  localparam logic [2:0] GRP_HI = 3'h1;
  localparam logic [2:0] GRP_LO = 3'h2;
  localparam logic [2:0] GRP_HYS = 3'h3;
  localparam logic [2:0] GRP_MIN = 3'h4;
  localparam logic [2:0] GRP_MAX = 3'h5;
  localparam logic [3:0] IDX_CFG = 4'h0;
  localparam logic [3:0] IDX_AFLAG = 4'h1;
  localparam logic [3:0] IDX_TFLAG = 4'h2;
  localparam logic [3:0] IDX_RESULT = 4'h3;
  // result word fields
  localparam int RES_CODE_LSB = 6;
  localparam int RES_CHID_LSB = 2;
  localparam int RES_TANY_BIT = 1;
  localparam int RES_AANY_BIT = 0;
  // alert pin source selection: a channel number or any channel
  localparam logic [3:0] SEL_ANY = 4'hf;
  localparam logic [11:0] CFG_RST = 12'hff0;
  // one conversion result from the converter
  typedef struct packed {
    logic [3:0] chan;
    logic [9:0] code;
  } almon_conv_t;
  // configuration word, bit 11 first
  typedef struct packed {
    logic [3:0] sel1;
    logic [3:0] sel0;
    logic pin1_en;
    logic pin0_en;
    logic pol_high;
    logic hyst_en;
  } almon_cfg_t;
  // apb read capture state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HELD = 2'b10
  } almon_apb_st_t;
endpackage : almon_pkg
`default_nettype wire

/* almon_host.sv */
/*
  apb master model standing in for the serial host that reaches the monitor registers.
  assumes a single pclk domain; the bench calls xfer hierarchically, one transfer at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module almon_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [almon_pkg::AW-1:0] paddr,
  output logic [almon_pkg::DW-1:0] pwdata,
  input wire logic [almon_pkg::DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import almon_pkg::*;
  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  // one transfer: setup, access held until pready, then release with scrambled lines
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output logic tmo);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    tmo = (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~wd;
  endtask : xfer
endmodule : almon_host
`default_nettype wire

/* almon_monitor_tb.sv */
/*
  self-checking bench for the monitor: register traffic through the host model, conversions driven here.
  assumes the host model and a 100 MHz pclk; clock enable held high except for one conversion.
*/
`timescale 1ns/1ps
`default_nettype none
module almon_monitor_tb;
  import almon_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_valid, pin0, pin1, clk_en;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata;
  almon_conv_t conv;
  int mismatches, cmp_count;
  // design and host
  almon_monitor dut_u (.pclk(pclk), .presetn(presetn), .pclk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_valid(conv_valid), .conv(conv), .first_alert_output_pin(pin0), .second_alert_output_pin(pin1));
  almon_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // verdict and end of run
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // bus access with timeout handling
  task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] wd,
                     output logic [31:0] d, output logic e);
    logic t;
    host_u.xfer(w, a, {16'h0, wd}, d, e, t);
    if (t !== 1'b0) begin
      mismatches++;
      $display("BAD %0t no pready", $time);
      report_and_stop();
    end
  endtask : acc
  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    logic [31:0] d;
    logic e;
    acc(1'b0, a, 16'h0, d, e);
    check(d, {16'h0, exp});
    check({31'h0, e}, 32'h0);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [15:0] wd);
    logic [31:0] d;
    logic e;
    acc(1'b1, a, wd, d, e);
  endtask : wr
  // one conversion strobe, then settle flags and pins
  task automatic cv(input logic [3:0] ch, input logic [9:0] code);
    @(posedge pclk);
    conv_valid <= 1'b1;
    conv <= '{chan: ch, code: code};
    @(posedge pclk);
    conv_valid <= 1'b0;
    conv <= '{chan: ~ch, code: ~code};
    repeat (3) @(posedge pclk);
  endtask : cv
  task automatic pins(input logic p0, input logic p1);
    check({30'h0, pin0, pin1}, {30'h0, p0, p1});
  endtask : pins
  // main sequence
  initial begin
    logic [31:0] d;
    logic e;
    presetn = 1'b0;
    conv_valid = 1'b0;
    clk_en = 1'b1;
    conv = '0;
    mismatches = 0;
    cmp_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    pins(1'b1, 1'b1);
    rd(12'h000, 16'h0ff0);
    for (int n = 0; n < NCH; n++) begin
      rd(12'h040 + 12'(4 * n), LIM_HI_RST);
      rd(12'h080 + 12'(4 * n), LIM_LO_RST);
      rd(12'h0c0 + 12'(4 * n), HYST_RST);
      rd(12'h100 + 12'(4 * n), MIN_RST);
      rd(12'h140 + 12'(4 * n), MAX_RST);
    end
    wr(12'h044, 16'h803f);
    rd(12'h044, 16'h8000);
    wr(12'h000, 16'h081e);
    cv(4'h1, 10'h201);
    rd(12'h004, 16'h0008);
    pins(1'b1, 1'b0);
    wr(12'h09c, 16'h1000);
    cv(4'h7, 10'h03f);
    rd(12'h004, 16'h4008);
    rd(12'h00c, 16'h0fdd);
    cv(4'h1, 10'h200);
    rd(12'h004, 16'h4000);
    pins(1'b0, 1'b0);
    // hysteresis of two codes on channel 1
    wr(12'h000, 16'h081f);
    wr(12'h0c4, 16'h0080);
    cv(4'h1, 10'h201);
    cv(4'h1, 10'h1ff);
    rd(12'h004, 16'h4008);
    pins(1'b1, 1'b0);
    cv(4'h1, 10'h1fe);
    rd(12'h004, 16'h4000);
    pins(1'b0, 1'b0);
    // temperature channel
    wr(12'h0a0, 16'h1000);
    cv(4'h8, 10'h010);
    rd(12'h008, 16'h0001);
    pins(1'b0, 1'b1);
    rd(12'h00c, 16'h0423);
    rd(12'h404, 16'h4000);
    rd(12'h004, 16'h0000);
    cv(4'h7, 10'h03f);
    wr(12'h004, 16'hffff);
    wr(12'h008, 16'h0003);
    rd(12'h004, 16'h0000);
    rd(12'h008, 16'h0000);
    // min and max of channel 1
    rd(12'h104, 16'h7f80);
    rd(12'h144, 16'h8040);
    wr(12'h144, 16'h1234);
    rd(12'h144, 16'h0000);
    rd(12'h504, 16'h7f80);
    rd(12'h104, 16'hffc0);
    // a conversion while the clock enable is low must leave max untouched
    clk_en <= 1'b0;
    cv(4'h1, 10'h3ff);
    clk_en <= 1'b1;
    rd(12'h144, 16'h0000);
    cv(4'h1, 10'h100);
    rd(12'h104, 16'h4000);
    wr(12'h104, 16'h0001);
    rd(12'h104, 16'hffc0);
    // unmapped place answers with an error and zero data
    acc(1'b0, 12'h180, 16'h0, d, e);
    check({d[31:1], e}, 32'h1);
    report_and_stop();
  end
endmodule : almon_monitor_tb
`default_nettype wire
